// ---- design/servo_fault_pkg.sv ----
package servo_fault_pkg;

  // ---------------------------------------------------------------
  // Alarm sources, one bit each
  // ---------------------------------------------------------------
  localparam int ALM_W        = 17;
  localparam int ALM_SENSOR   = 0;
  localparam int ALM_POSDATA  = 1;
  localparam int ALM_MOTCABLE = 2;
  localparam int ALM_OVERSPD  = 3;
  localparam int ALM_COMMUT   = 4;
  localparam int ALM_CPU      = 5;
  localparam int ALM_RAM      = 6;
  localparam int ALM_ROM      = 7;
  localparam int ALM_SYSTEM   = 8;
  localparam int ALM_IFACE    = 9;
  localparam int ALM_ADC      = 10;
  localparam int ALM_EHALT    = 11;
  localparam int ALM_HEAT     = 12;
  localparam int ALM_OVOLT    = 13;
  localparam int ALM_OCURR    = 14;
  localparam int ALM_LOWCTL   = 15;
  localparam int ALM_PWRMOD   = 16;

  // ---------------------------------------------------------------
  // Warning sources, one bit each
  // ---------------------------------------------------------------
  localparam int WRN_W        = 7;
  localparam int WRN_OVLOAD   = 0;
  localparam int WRN_HOME     = 1;
  localparam int WRN_CMDFB    = 2;
  localparam int WRN_POSERR   = 3;
  localparam int WRN_PROG     = 4;
  localparam int WRN_TUNE     = 5;
  localparam int WRN_LOWMAIN  = 6;

  // Warnings that remove servo power at once.
  localparam logic [WRN_W-1:0] WRN_SERVO_OFF_MASK = 7'h4D;
  // Warnings that stop the motor only after the current operation.
  localparam logic [WRN_W-1:0] WRN_CYCLE_STOP_MASK = 7'h30;
  // Alarms never written into history.
  localparam logic [ALM_W-1:0] ALM_NO_HIST_MASK = 17'h00840;
  // Alarms written only while recording still works.
  localparam logic [ALM_W-1:0] ALM_COND_HIST_MASK = 17'h000A0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ      = 25000000;
  localparam longint INIT_MS     = 3000;
  localparam longint INIT_CYCLES = (INIT_MS * CLK_HZ) / 1000;

  typedef enum logic [1:0] {
    PWR_OFF_T,
    PWR_ORANGE,
    PWR_GREEN
  } power_led_t;

  // Front panel indication.
  typedef struct packed {
    power_led_t       power_led;
    logic             code_valid;
    logic [4:0]       code_index;
    logic             code_is_warning;
  } panel_t;

  // History write port, one pulse per recorded event.
  typedef struct packed {
    logic             valid;
    logic             is_warning;
    logic [4:0]       index;
  } history_t;

endpackage

// ---- design/servo_fault_status_manager.sv ----
`timescale 1ns/1ps
`default_nettype none

module servo_fault_status_manager
  import servo_fault_pkg::*;
#(
  parameter longint INIT_COUNT = servo_fault_pkg::INIT_CYCLES
) (
  // Clock and reset
  input  wire logic                                clock,
  input  wire logic                                sys_rst,
  // Host discrete inputs, asynchronous pins
  input  wire logic                                servo_on_request,
  input  wire logic                                halt_input,
  input  wire logic                                emergency_halt_input,
  input  wire logic                                fault_clear_input,
  // Internal requests on this clock
  input  wire logic                                clear_fault_command,
  input  wire logic                                fault_query_command,
  input  wire logic                                op_request,
  input  wire logic                                op_dir_plus,
  input  wire logic                                motion_active,
  input  wire logic                                servo_established,
  input  wire logic                                history_writable,
  // Fault detectors on this clock, levels
  input  wire logic [servo_fault_pkg::ALM_W-1:0]   alarm_cause,
  input  wire logic [servo_fault_pkg::WRN_W-1:0]   warning_cause,
  input  wire logic                                limit_plus_cause,
  input  wire logic                                limit_minus_cause,
  // Polarity configuration: 1 means negative logic
  input  wire logic                                ready_negative,
  input  wire logic                                minor_negative,
  input  wire logic                                limit_negative,
  // Status outputs, 1 means the contact is closed
  output logic                                     drive_ready_out,
  output logic                                     minor_fault_out,
  output logic                                     travel_limit_plus_out,
  output logic                                     travel_limit_minus_out,
  output logic                                     servo_state_out,
  // Motor control
  output logic                                     servo_enable,
  output logic                                     dynamic_brake,
  output logic                                     op_execute,
  // Panel, history and query answer
  output servo_fault_pkg::panel_t                  panel,
  output servo_fault_pkg::history_t                history,
  output logic [servo_fault_pkg::ALM_W-1:0]        alarm_status,
  output logic [servo_fault_pkg::WRN_W-1:0]        warning_status
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  logic       son_s;
  logic       halt_s;
  logic       ehalt_s;
  logic       fclr_s;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
    end else begin
      pin_meta_q <= {fault_clear_input, emergency_halt_input,
                     halt_input, servo_on_request};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign son_s   = pin_sync_q[0];
  assign halt_s  = pin_sync_q[1];
  assign ehalt_s = pin_sync_q[2];
  assign fclr_s  = pin_sync_q[3];

  // ---------------------------------------------------------------
  // Power-up initialization
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_INIT,
    ST_RUN
  } phase_t;

  phase_t      phase_q;
  logic [31:0] init_cnt_q;
  logic        init_done;

  assign init_done = (init_cnt_q == 32'(INIT_COUNT - 1));

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      phase_q    <= ST_INIT;
      init_cnt_q <= 32'h0;
    end else begin
      case (phase_q)
        ST_INIT: begin
          init_cnt_q <= init_cnt_q + 32'h1;
          if (init_done) begin
            phase_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          phase_q <= ST_RUN;
        end
        default: begin
          phase_q <= ST_INIT;
        end
      endcase
    end
  end

  logic running;
  assign running = (phase_q == ST_RUN);

  // ---------------------------------------------------------------
  // Fault latches
  // ---------------------------------------------------------------
  // Emergency halt is a live level: it clears three cycles after the input is
  // released. Other alarms latch until reset, the power cycle here.
  logic [ALM_W-1:0] alarm_q;
  logic [ALM_W-1:0] alarm_src;
  logic [ALM_W-1:0] alarm_d;
  logic [WRN_W-1:0] warn_q;
  logic [WRN_W-1:0] warn_d;
  logic             warn_clear;

  always_comb begin
    alarm_src            = alarm_cause;
    alarm_src[ALM_EHALT] = ehalt_s;
  end

  always_comb begin
    alarm_d            = alarm_q | (alarm_src & {ALM_W{running}});
    alarm_d[ALM_EHALT] = running & ehalt_s;
  end

  assign warn_clear = fclr_s | clear_fault_command;
  // A cause still present wins over a clear in the same cycle.
  assign warn_d = running ? ((warn_q & ~{WRN_W{warn_clear}}) | warning_cause)
                          : '0;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      alarm_q <= '0;
      warn_q  <= '0;
    end else begin
      alarm_q <= alarm_d;
      warn_q  <= warn_d;
    end
  end

  // Travel limits follow the position live and clear on their own.
  logic lim_plus;
  logic lim_minus;
  assign lim_plus  = running & limit_plus_cause;
  assign lim_minus = running & limit_minus_cause;

  // ---------------------------------------------------------------
  // Motor control
  // ---------------------------------------------------------------
  logic any_alarm;
  logic any_warn;
  logic warn_off_now;
  logic cycle_stop_pending;
  logic servo_allowed;
  logic dir_ok;

  assign any_alarm    = |alarm_q;
  assign any_warn     = |warn_q;
  assign warn_off_now = |(warn_q & WRN_SERVO_OFF_MASK);
  // Program and tuning warnings let the running move finish first.
  assign cycle_stop_pending =
    (|(warn_q & WRN_CYCLE_STOP_MASK)) & ~motion_active;
  // Alarm term is independent of warnings, so a clear cannot undo it.
  assign servo_allowed = running & son_s & ~any_alarm
                       & ~warn_off_now & ~cycle_stop_pending;
  assign dir_ok = ~(lim_plus & op_dir_plus)
                & ~(lim_minus & ~op_dir_plus);

  logic servo_q;
  logic servo_state_q;
  logic op_q;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      servo_q       <= 1'b0;
      servo_state_q <= 1'b0;
      op_q          <= 1'b0;
    end else begin
      servo_q       <= servo_allowed;
      servo_state_q <= servo_allowed & servo_established;
      op_q          <= op_request & servo_allowed & servo_established
                     & ~halt_s & dir_ok;
    end
  end

  assign servo_enable    = servo_q;
  assign dynamic_brake   = ~servo_q;
  assign servo_state_out = servo_state_q;
  assign op_execute      = op_q;

  // ---------------------------------------------------------------
  // Status contacts
  // ---------------------------------------------------------------
  // Contact level: 1 closed while healthy. Negative setting inverts.
  function automatic logic contact(input logic healthy,
                                   input logic negative);
    contact = negative ? ~healthy : healthy;
  endfunction

  logic ready_q;
  logic minor_q;
  logic lplus_q;
  logic lminus_q;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ready_q  <= 1'b0;
      minor_q  <= 1'b0;
      lplus_q  <= 1'b0;
      lminus_q <= 1'b0;
    end else begin
      ready_q  <= running & ~any_alarm;
      minor_q  <= running & ~any_warn;
      lplus_q  <= running & ~lim_plus;
      lminus_q <= running & ~lim_minus;
    end
  end

  // Shipped polarity comes from the configuration inputs.
  assign drive_ready_out        = contact(ready_q, ready_negative);
  assign minor_fault_out        = contact(minor_q, minor_negative);
  assign travel_limit_plus_out  = contact(lplus_q, limit_negative);
  assign travel_limit_minus_out = contact(lminus_q, limit_negative);

  // ---------------------------------------------------------------
  // Panel and query answer
  // ---------------------------------------------------------------
  function automatic logic [4:0] first_set(input logic [ALM_W-1:0] v);
    first_set = 5'h0;
    for (int i = ALM_W - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 5'(i);
      end
    end
  endfunction

  logic   any_fault;
  panel_t panel_d;
  panel_t panel_q;

  assign any_fault = any_alarm | any_warn | lim_plus | lim_minus;

  always_comb begin
    panel_d.power_led       = (~running | any_fault) ? PWR_ORANGE
                                                     : PWR_GREEN;
    panel_d.code_valid      = any_fault;
    panel_d.code_is_warning = ~any_alarm & any_warn;
    panel_d.code_index      = any_alarm ? first_set(alarm_q)
                            : first_set({{(ALM_W-WRN_W){1'b0}}, warn_q});
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      panel_q        <= '{PWR_ORANGE, 1'b0, 5'h0, 1'b0};
      alarm_status   <= '0;
      warning_status <= '0;
    end else begin
      panel_q <= panel_d;
      if (fault_query_command) begin
        alarm_status   <= alarm_q;
        warning_status <= warn_q;
      end
    end
  end

  assign panel = panel_q;

  // ---------------------------------------------------------------
  // History recording
  // ---------------------------------------------------------------
  // One new fault per cycle is logged; a rare second one in the same
  // cycle waits, because its pending bit stays set until recorded.
  logic [ALM_W-1:0] alm_new;
  logic [WRN_W-1:0] wrn_new;
  logic [ALM_W-1:0] alm_rec_q;
  logic [WRN_W-1:0] wrn_rec_q;
  logic [ALM_W-1:0] alm_pend;
  logic [WRN_W-1:0] wrn_pend;
  logic [ALM_W-1:0] alm_ok;
  logic [4:0]       pick_a;
  logic [4:0]       pick_w;
  history_t         hist_q;

  assign alm_ok   = ~ALM_NO_HIST_MASK
                  & (history_writable ? '1 : ~ALM_COND_HIST_MASK);
  assign alm_new  = alarm_q & alm_ok;
  assign wrn_new  = warn_q;
  assign alm_pend = alm_new & ~alm_rec_q;
  assign wrn_pend = wrn_new & ~wrn_rec_q;
  assign pick_a   = first_set(alm_pend);
  assign pick_w   = first_set({{(ALM_W-WRN_W){1'b0}}, wrn_pend});

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      alm_rec_q <= '0;
      wrn_rec_q <= '0;
      hist_q    <= '0;
    end else begin
      hist_q    <= '0;
      wrn_rec_q <= wrn_rec_q & warn_q;
      if (|alm_pend) begin
        alm_rec_q[pick_a] <= 1'b1;
        hist_q            <= '{1'b1, 1'b0, pick_a};
      end else if (|wrn_pend) begin
        wrn_rec_q[pick_w[2:0]] <= 1'b1;
        hist_q                 <= '{1'b1, 1'b1, pick_w};
      end
    end
  end

  assign history = hist_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_alarm_servo_off;
    @(posedge clock) disable iff (sys_rst)
    any_alarm |=> !servo_enable && dynamic_brake;
  endproperty
  a_alarm_servo_off: assert property (p_alarm_servo_off)
    else $error("alarm did not force servo off");

  property p_brake_when_off;
    @(posedge clock) disable iff (sys_rst)
    !son_s |=> dynamic_brake && !servo_enable;
  endproperty
  a_brake_when_off: assert property (p_brake_when_off)
    else $error("brake not applied while servo off");

  property p_halt_blocks;
    @(posedge clock) disable iff (sys_rst)
    halt_s |=> !op_execute;
  endproperty
  a_halt_blocks: assert property (p_halt_blocks)
    else $error("operation executed while halted");

  property p_init_quiet;
    @(posedge clock) disable iff (sys_rst)
    !running |=> !servo_enable && !ready_q && !minor_q && !servo_state_out;
  endproperty
  a_init_quiet: assert property (p_init_quiet)
    else $error("output active during initialization");

  property p_servo_state_out_needs_servo;
    @(posedge clock) disable iff (sys_rst)
    servo_state_out |-> servo_enable;
  endproperty
  a_servo_state_out_needs_servo: assert property (p_servo_state_out_needs_servo)
    else $error("servo state closed without servo");

  sequence s_ehalt_released;
    running && $fell(ehalt_s) && !$past(alarm_cause[ALM_EHALT]);
  endsequence
  property p_ehalt_clears;
    @(posedge clock) disable iff (sys_rst)
    s_ehalt_released |=> !alarm_q[ALM_EHALT];
  endproperty
  a_ehalt_clears: assert property (p_ehalt_clears)
    else $error("emergency halt alarm did not clear");

  property p_alarm_latched;
    @(posedge clock) disable iff (sys_rst)
    alarm_q[ALM_OVERSPD] |=> alarm_q[ALM_OVERSPD];
  endproperty
  a_alarm_latched: assert property (p_alarm_latched)
    else $error("latched alarm dropped");

  property p_warn_set_wins;
    @(posedge clock) disable iff (sys_rst)
    running && warning_cause[WRN_HOME] && warn_clear |=> warn_q[WRN_HOME];
  endproperty
  a_warn_set_wins: assert property (p_warn_set_wins)
    else $error("warning lost against clear");

  property p_no_ehalt_history;
    @(posedge clock) disable iff (sys_rst)
    history.valid && !history.is_warning |->
      history.index != 5'(ALM_EHALT) && history.index != 5'(ALM_RAM);
  endproperty
  a_no_ehalt_history: assert property (p_no_ehalt_history)
    else $error("excluded alarm recorded");

  property p_limit_dir;
    @(posedge clock) disable iff (sys_rst)
    lim_plus && op_dir_plus |=> !op_execute;
  endproperty
  a_limit_dir: assert property (p_limit_dir)
    else $error("motion into limit accepted");

endmodule

`default_nettype wire

// ---- verification/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module host_model #(
  parameter int INIT_LIMIT = 250
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Requests from the sequencer
  input  wire logic want_servo,
  input  wire logic want_halt,
  input  wire logic want_ehalt,
  input  wire logic want_clear,
  input  wire logic want_op,
  // Drive status seen by the host
  input  wire logic servo_state_out,
  input  wire logic drive_ready_out,
  // Discrete pins towards the drive
  output logic      servo_on_request,
  output logic      halt_input,
  output logic      emergency_halt_input,
  output logic      fault_clear_input,
  output logic      op_request,
  output logic      init_fail
);
  logic seen_q;
  int   wait_q;

  assign init_fail = (wait_q >= INIT_LIMIT);

  // Motion is only asked for once the drive reports servo established.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      seen_q               <= 1'b0;
      wait_q               <= 0;
      servo_on_request     <= 1'b0;
      halt_input           <= 1'b0;
      emergency_halt_input <= 1'b0;
      fault_clear_input    <= 1'b0;
      op_request           <= 1'b0;
    end else begin
      servo_on_request     <= want_servo;
      halt_input           <= want_halt;
      emergency_halt_input <= want_ehalt;
      fault_clear_input    <= want_clear;
      op_request           <= want_op & servo_state_out;
      if (drive_ready_out) seen_q <= 1'b1;
      else if (!seen_q && !init_fail) wait_q <= wait_q + 1;
    end
  end
endmodule

`default_nettype wire

// ---- verification/servo_fault_status_manager_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module servo_fault_status_manager_test;
  import servo_fault_pkg::*;
  localparam int INIT = 20;
  logic             clock, sys_rst, w_sv, w_halt, w_eh, w_clr, w_op;
  logic             son, hlt, ehl, fcl, opr, ifail;
  logic             clr_cmd, qry, dirp, mact, est, hw, lp, lm;
  logic             rneg, mneg, lneg;
  logic [ALM_W-1:0] acause, ast;
  logic [WRN_W-1:0] wcause, wst;
  logic             rdy, mnr, tlp, tlm, sst, sen, brk, opx;
  panel_t           panel;
  history_t         hist;
  logic [7:0]       eq[$];
  logic [5:0]       hq[$];
  int               fails, total_checks;
  event             look;
  wire  [7:0]       obs = {rdy, mnr, tlp, tlm, sst, sen, brk, opx};

  host_model #(.INIT_LIMIT(10 * INIT)) host_model_inst (
    .clock(clock), .sys_rst(sys_rst), .want_servo(w_sv),
    .want_halt(w_halt), .want_ehalt(w_eh), .want_clear(w_clr),
    .want_op(w_op), .servo_state_out(sst), .drive_ready_out(rdy),
    .servo_on_request(son), .halt_input(hlt),
    .emergency_halt_input(ehl), .fault_clear_input(fcl),
    .op_request(opr), .init_fail(ifail));

  servo_fault_status_manager #(.INIT_COUNT(INIT))
    servo_fault_status_manager_inst (
    .clock(clock), .sys_rst(sys_rst), .servo_on_request(son),
    .halt_input(hlt), .emergency_halt_input(ehl),
    .fault_clear_input(fcl), .clear_fault_command(clr_cmd),
    .fault_query_command(qry), .op_request(opr), .op_dir_plus(dirp),
    .motion_active(mact), .servo_established(est),
    .history_writable(hw), .alarm_cause(acause),
    .warning_cause(wcause), .limit_plus_cause(lp),
    .limit_minus_cause(lm), .ready_negative(rneg),
    .minor_negative(mneg), .limit_negative(lneg),
    .drive_ready_out(rdy), .minor_fault_out(mnr),
    .travel_limit_plus_out(tlp), .travel_limit_minus_out(tlm),
    .servo_state_out(sst), .servo_enable(sen), .dynamic_brake(brk),
    .op_execute(opx), .panel(panel), .history(hist),
    .alarm_status(ast), .warning_status(wst));

  // ----------------------------------------------------------------
  // Helpers and result watchers
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Healthy levels in, contacts out; the polarity inputs invert groups.
  function automatic logic [7:0] ex(input logic r, m, p, q, s, e, o);
    return {r ^ rneg, m ^ mneg, p ^ lneg, q ^ lneg, s, e, ~e, o};
  endfunction

  task automatic chk(input logic [7:0] e);
    @(negedge clock);
    eq.push_back(e);
    ->look;
    @(posedge clock);
  endtask

  task automatic cmp(input string n, input logic [31:0] e, s);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask

  task automatic reboot;
    sys_rst <= 1'b1;
    cyc(10);
    sys_rst <= 1'b0;
    cyc(INIT + 8);
  endtask

  task automatic test_done;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    logic [7:0] e;
    forever begin
      @(look);
      e = eq.pop_front();
      cmp("outputs", 32'(e), 32'(obs));
    end
  end

  // Records are looked at mid-cycle, where the registered pulse is settled.
  always @(negedge clock) begin
    if (hist.valid === 1'b1) begin
      if (hq.size() == 0) hq.push_back(6'h3F);
      cmp("history", 32'(hq.pop_front()),
          32'({hist.is_warning, hist.index}));
    end
  end

  initial begin
    cyc(20000);
    fails++;
    test_done;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic e, hb;
    void'($urandom(32'h771F));
    {w_sv, w_halt, w_eh, w_clr, w_op, clr_cmd, qry} = '0;
    {dirp, mact, est, hw, lp, lm} = '0;
    acause = '0;
    wcause = '0;
    {rneg, mneg, lneg} = 3'b011;
    sys_rst = 1'b1;
    cyc(10);
    sys_rst <= 1'b0;
    cyc(3);
    @(negedge clock);
    cmp("led", PWR_ORANGE, panel.power_led);
    chk(ex(0, 0, 0, 0, 0, 0, 0));
    cyc(INIT + 5);
    chk(ex(1, 1, 1, 1, 0, 0, 0));
    w_sv <= 1'b1;
    cyc(5);
    chk(ex(1, 1, 1, 1, 0, 1, 0));
    est <= 1'b1;
    cyc(3);
    chk(ex(1, 1, 1, 1, 1, 1, 0));
    w_halt <= 1'b1;
    w_op <= 1'b1;
    cyc(6);
    chk(ex(1, 1, 1, 1, 1, 1, 0));
    w_halt <= 1'b0;
    cyc(5);
    chk(ex(1, 1, 1, 1, 1, 1, 1));
    lp <= 1'b1;
    dirp <= 1'b1;
    cyc(3);
    chk(ex(1, 1, 0, 1, 1, 1, 0));
    dirp <= 1'b0;
    cyc(2);
    chk(ex(1, 1, 0, 1, 1, 1, 1));
    lp <= 1'b0;
    w_op <= 1'b0;
    cyc(3);
    chk(ex(1, 1, 1, 1, 1, 1, 0));
    for (int i = 0; i < WRN_W; i++) begin
      mact <= 1'b1;
      wcause[i] <= 1'b1;
      hq.push_back({1'b1, 5'(i)});
      cyc(3);
      e = !WRN_SERVO_OFF_MASK[i];
      chk(ex(1, 0, 1, 1, e, e, 0));
      mact <= 1'b0;
      qry <= 1'b1;
      cyc(3);
      e = !(WRN_SERVO_OFF_MASK[i] | WRN_CYCLE_STOP_MASK[i]);
      chk(ex(1, 0, 1, 1, e, e, 0));
      wcause[i] <= 1'b0;
      qry <= 1'b0;
      @(negedge clock);
      cmp("warnings", 32'(1) << i, 32'(wst));
      cmp("panel", 32'({PWR_ORANGE, 1'b1, 5'(i), 1'b1}), 32'(panel));
      cyc(3);
      chk(ex(1, 0, 1, 1, e, e, 0));
      if (i % 2) w_clr <= 1'b1;
      else clr_cmd <= 1'b1;
      cyc(5);
      w_clr <= 1'b0;
      clr_cmd <= 1'b0;
      cyc(3);
      @(negedge clock);
      cmp("panel", 32'({PWR_GREEN, 1'b0, 5'h0, 1'b0}), 32'(panel));
      chk(ex(1, 1, 1, 1, 1, 1, 0));
    end
    for (int i = 0; i < ALM_W; i++) begin
      if (i == ALM_EHALT) continue;
      hb = 1'($urandom);
      hw <= hb;
      acause[i] <= 1'b1;
      // A clear held while the cause rises must not stop the warning.
      clr_cmd <= 1'b1;
      wcause[WRN_HOME] <= 1'b1;
      if (!ALM_NO_HIST_MASK[i] && (!ALM_COND_HIST_MASK[i] || hb))
        hq.push_back({1'b0, 5'(i)});
      hq.push_back({1'b1, 5'(WRN_HOME)});
      cyc(3);
      acause[i] <= 1'b0;
      wcause <= '0;
      clr_cmd <= 1'b1;
      cyc(3);
      clr_cmd <= 1'b0;
      qry <= 1'b1;
      cyc(1);
      qry <= 1'b0;
      cyc(3);
      @(negedge clock);
      cmp("alarm", 32'(1) << i, 32'(ast));
      cmp("warnings", 0, 32'(wst));
      cmp("code", i, 32'(panel.code_index));
      cmp("panel", 32'({PWR_ORANGE, 1'b1, 5'(i), 1'b0}), 32'(panel));
      chk(ex(0, 1, 1, 1, 0, 0, 0));
      reboot;
    end
    {rneg, mneg, lneg} <= 3'b100;
    w_eh <= 1'b1;
    cyc(6);
    @(negedge clock);
    cmp("led", PWR_ORANGE, panel.power_led);
    chk(ex(0, 1, 1, 1, 0, 0, 0));
    w_eh <= 1'b0;
    cyc(6);
    chk(ex(1, 1, 1, 1, 1, 1, 0));
    cmp("init", 0, 32'(ifail));
    cmp("pending", 0, hq.size());
    test_done;
  end
endmodule

`default_nettype wire
